// >>> include/corr_pkg.sv
package corr_pkg;
    localparam int RAW_W  = 14;
    localparam int COEF_W = 16;
    localparam int OUT_W  = 16;
    localparam int DW     = 40;
    localparam int SH_W   = 6;

    localparam logic [RAW_W-1:0]  HALF_SCALE  = 14'h2000;
    localparam logic [DW-1:0]     UNITY       = 40'h00_0001_0000;
    localparam logic [SH_W-1:0]   DEN_FRAC    = 6'h10;
    localparam logic [SH_W-1:0]   DRIFT_FRAC  = 6'h10;
    localparam logic [SH_W-1:0]   SQ_FRAC     = 6'h0E;
    localparam logic [SH_W-1:0]   GAIN_FRAC   = 6'h0D;
    localparam logic [SH_W-1:0]   FS_FRAC     = 6'h10;
    localparam logic [SH_W-1:0]   COEF_FRAC   = 6'h0F;
    localparam logic [SH_W-1:0]   T_SQ_FRAC   = 6'h0E;
    localparam logic [SH_W-1:0]   T_GAIN_FRAC = 6'h0E;
    localparam logic [OUT_W-1:0]  CAP_MAX     = 16'hFFFF;
    localparam logic [OUT_W-1:0]  TEMP_MAX    = 16'h7FFF;
    localparam logic [OUT_W-1:0]  TEMP_MIN    = 16'h8000;
    localparam logic [OUT_W-1:0]  RESULT_RST  = 16'h0000;

    typedef enum logic [4:0] {
        S_IDLE, S_OFS2, S_OFS1, S_GN2, S_GN1, S_DIV, S_WAIT, S_SPLIT,
        S_LIN, S_SQ, S_SQC, S_CU, S_CUC, S_TSQ, S_TSQC, S_TG, S_DONE
    } state_t;
endpackage : corr_pkg

// >>> include/math_if.sv
`timescale 1ns/1ps
interface math_if #(parameter int W = 40);
    logic signed [W-1:0] mul_a;
    logic signed [W-1:0] mul_b;
    logic        [5:0]   mul_sh;
    logic signed [W-1:0] mul_p;
    logic                div_start;
    logic signed [W-1:0] div_num;
    logic signed [W-1:0] div_den;
    logic                div_done;
    logic signed [W-1:0] div_q;

    modport ctrl (output mul_a, mul_b, mul_sh, div_start, div_num, div_den,
                  input  mul_p, div_done, div_q);
    modport mul  (input  mul_a, mul_b, mul_sh, output mul_p);
    modport div  (input  div_start, div_num, div_den, output div_done, div_q);
endinterface : math_if

// >>> hdl/corr_multiplier.sv
`timescale 1ns/1ps
module corr_multiplier #(
    parameter int W = 40
) (
    math_if.mul m
);
    logic signed [2*W-1:0] prod;
    logic signed [2*W-1:0] shifted;
    logic                  fits;

    if (W < 8) $error("corr_multiplier: W too small");

    // Saturate instead of wrapping so a wild coefficient cannot flip sign
    always_comb begin
        prod    = (2*W)'(m.mul_a) * (2*W)'(m.mul_b);
        shifted = prod >>> m.mul_sh;
        fits    = (shifted[2*W-1:W-1] == '0) || (shifted[2*W-1:W-1] == '1);
        if (fits) begin
            m.mul_p = shifted[W-1:0];
        end else if (shifted[2*W-1]) begin
            m.mul_p = {1'b1, {(W-1){1'b0}}};
        end else begin
            m.mul_p = {1'b0, {(W-1){1'b1}}};
        end
    end
endmodule : corr_multiplier

// >>> hdl/corr_divider.sv
`timescale 1ns/1ps
module corr_divider #(
    parameter int W = 40
) (
    input wire logic clk_i,
    input wire logic rst_i,
    math_if.div      m
);
    localparam int CW = $clog2(W + 1);

    logic [W-1:0]  quo;
    logic [W-1:0]  next_quo;
    logic [W-1:0]  dmag;
    logic [W-1:0]  next_dmag;
    logic [W:0]    rem;
    logic [W:0]    next_rem;
    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;
    logic          neg;
    logic          next_neg;
    logic          busy;
    logic          next_busy;
    logic          done;
    logic          next_done;
    logic [W:0]    shifted;
    logic [W:0]    trial;

    if (W < 8) $error("corr_divider: W too small");

    // Restoring division, one quotient bit per clock; divisor must be positive
    always_comb begin
        next_quo  = quo;
        next_dmag = dmag;
        next_rem  = rem;
        next_cnt  = cnt;
        next_neg  = neg;
        next_busy = busy;
        next_done = 1'b0;
        shifted   = {rem[W-1:0], quo[W-1]};
        trial     = shifted - {1'b0, dmag};
        if (!busy && m.div_start) begin
            next_neg  = m.div_num[W-1];
            next_quo  = m.div_num[W-1] ? W'(-m.div_num) : m.div_num;
            next_dmag = m.div_den;
            next_rem  = '0;
            next_cnt  = CW'(W);
            next_busy = 1'b1;
        end else if (busy) begin
            next_rem  = trial[W] ? shifted : trial;
            next_quo  = {quo[W-2:0], ~trial[W]};
            next_cnt  = cnt - 1'b1;
            if (cnt == CW'(1)) begin
                next_busy = 1'b0;
                next_done = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            quo  <= '0;
            dmag <= '0;
            rem  <= '0;
            cnt  <= '0;
            neg  <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            quo  <= next_quo;
            dmag <= next_dmag;
            rem  <= next_rem;
            cnt  <= next_cnt;
            neg  <= next_neg;
            busy <= next_busy;
            done <= next_done;
        end
    end

    assign m.div_done = done;
    assign m.div_q    = neg ? W'(-quo) : quo;
endmodule : corr_divider

// >>> hdl/sensor_correction_math.sv
`timescale 1ns/1ps
module sensor_correction_math (
    // Clock and reset
    input  wire logic        CLK_I,
    input  wire logic        RESET_I,
    // Measurement request
    input  wire logic        START_I,
    input  wire logic [13:0] RAW_CAP_I,
    input  wire logic [13:0] RAW_TEMP_I,
    // Mode: 0 two-region quadratic, 1 single-region cubic
    input  wire logic        THIRD_ORDER_I,
    // Drift coefficients
    input  wire logic [15:0] SENSOR_OFFSET_I,
    input  wire logic [13:0] REF_TEMP_I,
    input  wire logic [15:0] OFFSET_DRIFT_I,
    input  wire logic [15:0] OFFSET_DRIFT_SQUARE_COEF_I,
    input  wire logic [15:0] GAIN_DRIFT_I,
    input  wire logic [15:0] GAIN_DRIFT_SQUARE_COEF_I,
    // Region coefficients
    input  wire logic [15:0] REGION_BREAK_I,
    input  wire logic [15:0] REGION_ONE_GAIN_I,
    input  wire logic [15:0] REGION_ONE_SQUARE_COEF_I,
    input  wire logic [15:0] REGION_TWO_GAIN_I,
    input  wire logic [15:0] REGION_TWO_SQUARE_COEF_I,
    // Temperature coefficients
    input  wire logic [15:0] TEMPERATURE_GAIN_I,
    input  wire logic [15:0] TEMPERATURE_OFFSET_I,
    input  wire logic [15:0] TEMPERATURE_SQUARE_COEF_I,
    // Results
    output logic             BUSY_O,
    output logic             RESULT_VALID_O,
    output logic [15:0]      CAP_OUT_O,
    output logic [15:0]      TEMP_OUT_O
);
    localparam int DW = corr_pkg::DW;

    if (corr_pkg::RAW_W != 14 || corr_pkg::COEF_W != 16 || DW < 40)
        $error("sensor_correction_math: unsupported widths");

    math_if #(.W(DW)) mif ();

    corr_multiplier #(.W(DW)) u_mul (
        .m (mif.mul)
    );

    corr_divider #(.W(DW)) u_div (
        .clk_i (CLK_I),
        .rst_i (RESET_I),
        .m     (mif.div)
    );

    corr_pkg::state_t       state;
    corr_pkg::state_t       next_state;
    logic                   region;
    logic                   next_region;
    logic                   cubic_mode;
    logic                   next_cubic_mode;
    logic signed [DW-1:0]   raw_c;
    logic signed [DW-1:0]   next_raw_c;
    logic signed [DW-1:0]   raw_t;
    logic signed [DW-1:0]   next_raw_t;
    logic signed [DW-1:0]   dt;
    logic signed [DW-1:0]   next_dt;
    logic signed [DW-1:0]   tmp;
    logic signed [DW-1:0]   next_tmp;
    logic signed [DW-1:0]   num;
    logic signed [DW-1:0]   next_num;
    logic signed [DW-1:0]   den;
    logic signed [DW-1:0]   next_den;
    logic signed [DW-1:0]   reg_one;
    logic signed [DW-1:0]   next_reg_one;
    logic signed [DW-1:0]   reg_two;
    logic signed [DW-1:0]   next_reg_two;
    logic signed [DW-1:0]   y;
    logic signed [DW-1:0]   next_y;
    logic signed [DW-1:0]   sq;
    logic signed [DW-1:0]   next_sq;
    logic signed [DW-1:0]   acc;
    logic signed [DW-1:0]   next_acc;
    logic signed [DW-1:0]   tacc;
    logic signed [DW-1:0]   next_tacc;
    logic                   busy;
    logic                   next_busy;
    logic                   valid;
    logic                   next_valid;
    logic [15:0]            cap_out;
    logic [15:0]            next_cap_out;
    logic [15:0]            temp_out;
    logic [15:0]            next_temp_out;
    logic signed [DW-1:0]   raw_tc;
    logic signed [DW-1:0]   brk;
    logic signed [DW-1:0]   den_sum;

    // Sign extension of a 16-bit coefficient to datapath width
    function automatic logic signed [DW-1:0] sx(input logic [15:0] v);
        sx = DW'($signed(v));
    endfunction : sx

    // Zero extension of an unsigned field
    function automatic logic signed [DW-1:0] zx(input logic [15:0] v);
        zx = {{(DW-16){1'b0}}, v};
    endfunction : zx

    assign brk     = zx(REGION_BREAK_I);
    assign raw_tc  = mif.div_q + zx({2'b00, corr_pkg::HALF_SCALE});

    // Multiplier operand steering, one product per state
    always_comb begin
        mif.mul_a  = '0;
        mif.mul_b  = '0;
        mif.mul_sh = '0;
        case (state)
            corr_pkg::S_OFS2: begin
                mif.mul_a  = dt;
                mif.mul_b  = sx(OFFSET_DRIFT_SQUARE_COEF_I);
                mif.mul_sh = corr_pkg::SQ_FRAC;
            end
            corr_pkg::S_OFS1: begin
                mif.mul_a  = dt;
                mif.mul_b  = sx(OFFSET_DRIFT_I) + tmp;
                mif.mul_sh = corr_pkg::DRIFT_FRAC;
            end
            corr_pkg::S_GN2: begin
                mif.mul_a  = dt;
                mif.mul_b  = sx(GAIN_DRIFT_SQUARE_COEF_I);
                mif.mul_sh = corr_pkg::SQ_FRAC;
            end
            corr_pkg::S_GN1: begin
                mif.mul_a  = dt;
                mif.mul_b  = sx(GAIN_DRIFT_I) + tmp;
                mif.mul_sh = corr_pkg::DRIFT_FRAC;
            end
            corr_pkg::S_LIN: begin
                mif.mul_a  = region ? sx(REGION_TWO_GAIN_I) : sx(REGION_ONE_GAIN_I);
                mif.mul_b  = region ? reg_two : reg_one;
                mif.mul_sh = corr_pkg::GAIN_FRAC;
            end
            corr_pkg::S_SQ: begin
                mif.mul_a  = y;
                mif.mul_b  = y;
                mif.mul_sh = corr_pkg::FS_FRAC;
            end
            corr_pkg::S_SQC: begin
                mif.mul_a  = sq;
                mif.mul_b  = region ? sx(REGION_TWO_SQUARE_COEF_I)
                                    : sx(REGION_ONE_SQUARE_COEF_I);
                mif.mul_sh = corr_pkg::COEF_FRAC;
            end
            corr_pkg::S_CU: begin
                mif.mul_a  = sq;
                mif.mul_b  = y;
                mif.mul_sh = corr_pkg::FS_FRAC;
            end
            corr_pkg::S_CUC: begin
                mif.mul_a  = tmp;
                mif.mul_b  = sx(REGION_TWO_SQUARE_COEF_I);
                mif.mul_sh = corr_pkg::COEF_FRAC;
            end
            corr_pkg::S_TSQ: begin
                mif.mul_a  = raw_t;
                mif.mul_b  = raw_t;
                mif.mul_sh = corr_pkg::T_SQ_FRAC;
            end
            corr_pkg::S_TSQC: begin
                mif.mul_a  = tmp;
                mif.mul_b  = sx(TEMPERATURE_SQUARE_COEF_I);
                mif.mul_sh = corr_pkg::COEF_FRAC;
            end
            corr_pkg::S_TG: begin
                mif.mul_a  = sx(TEMPERATURE_GAIN_I);
                mif.mul_b  = raw_t;
                mif.mul_sh = corr_pkg::T_GAIN_FRAC;
            end
            default: begin
                mif.mul_a  = '0;
            end
        endcase
    end

    assign mif.div_start = (state == corr_pkg::S_DIV);
    // scaled division by one plus gain drift
    assign mif.div_num   = num <<< corr_pkg::DEN_FRAC;
    assign mif.div_den   = den;
    assign den_sum       = $signed(corr_pkg::UNITY) + mif.mul_p;

    // Sequencer
    always_comb begin
        next_state      = state;
        next_region     = region;
        next_cubic_mode = cubic_mode;
        next_raw_c      = raw_c;
        next_raw_t      = raw_t;
        next_dt         = dt;
        next_tmp        = tmp;
        next_num        = num;
        next_den        = den;
        next_reg_one    = reg_one;
        next_reg_two    = reg_two;
        next_y          = y;
        next_sq         = sq;
        next_acc        = acc;
        next_tacc       = tacc;
        next_busy       = busy;
        next_valid      = 1'b0;
        next_cap_out    = cap_out;
        next_temp_out   = temp_out;
        case (state)
            corr_pkg::S_IDLE: begin
                if (START_I) begin
                    next_cubic_mode = THIRD_ORDER_I;
                    next_raw_c      = zx({2'b00, RAW_CAP_I});
                    next_raw_t      = zx({2'b00, RAW_TEMP_I});
                    next_dt         = zx({2'b00, RAW_TEMP_I}) - zx({2'b00, REF_TEMP_I});
                    next_acc        = '0;
                    next_region     = 1'b0;
                    next_busy       = 1'b1;
                    next_state      = corr_pkg::S_OFS2;
                end
            end
            corr_pkg::S_OFS2: begin
                next_tmp   = mif.mul_p;
                next_state = corr_pkg::S_OFS1;
            end
            corr_pkg::S_OFS1: begin
                next_num   = raw_c - zx({2'b00, corr_pkg::HALF_SCALE})
                           + sx(SENSOR_OFFSET_I) + mif.mul_p;
                next_state = corr_pkg::S_GN2;
            end
            corr_pkg::S_GN2: begin
                next_tmp   = mif.mul_p;
                next_state = corr_pkg::S_GN1;
            end
            corr_pkg::S_GN1: begin
                next_den   = (den_sum < 1) ? DW'(1) : den_sum;
                next_state = corr_pkg::S_DIV;
            end
            corr_pkg::S_DIV: begin
                next_state = corr_pkg::S_WAIT;
            end
            corr_pkg::S_WAIT: begin
                if (mif.div_done) begin
                    if (!cubic_mode) begin
                        next_reg_one = (raw_tc < brk) ? raw_tc : brk;
                        next_reg_two = (raw_tc > brk) ? raw_tc - brk : '0;
                    end else begin
                        next_reg_one = raw_tc;
                        next_reg_two = '0;
                    end
                    next_state = corr_pkg::S_SPLIT;
                end
            end
            corr_pkg::S_SPLIT: begin
                next_state = corr_pkg::S_LIN;
            end
            corr_pkg::S_LIN: begin
                next_y     = mif.mul_p;
                next_acc   = acc + mif.mul_p;
                next_state = corr_pkg::S_SQ;
            end
            corr_pkg::S_SQ: begin
                next_sq    = mif.mul_p;
                next_state = corr_pkg::S_SQC;
            end
            corr_pkg::S_SQC: begin
                next_acc = acc + mif.mul_p;
                if (cubic_mode) begin
                    next_state = corr_pkg::S_CU;
                end else if (!region) begin
                    next_region = 1'b1;
                    next_state  = corr_pkg::S_LIN;
                end else begin
                    next_state = corr_pkg::S_TSQ;
                end
            end
            corr_pkg::S_CU: begin
                next_tmp   = mif.mul_p;
                next_state = corr_pkg::S_CUC;
            end
            corr_pkg::S_CUC: begin
                next_acc   = acc + mif.mul_p;
                next_state = corr_pkg::S_TSQ;
            end
            corr_pkg::S_TSQ: begin
                next_tmp   = mif.mul_p;
                next_state = corr_pkg::S_TSQC;
            end
            corr_pkg::S_TSQC: begin
                next_tacc  = mif.mul_p + sx(TEMPERATURE_OFFSET_I);
                next_state = corr_pkg::S_TG;
            end
            corr_pkg::S_TG: begin
                next_tacc  = tacc + mif.mul_p;
                next_state = corr_pkg::S_DONE;
            end
            corr_pkg::S_DONE: begin
                if (acc < 0) begin
                    next_cap_out = '0;
                end else if (acc > zx(corr_pkg::CAP_MAX)) begin
                    next_cap_out = corr_pkg::CAP_MAX;
                end else begin
                    next_cap_out = acc[15:0];
                end
                if (tacc > sx(corr_pkg::TEMP_MAX)) begin
                    next_temp_out = corr_pkg::TEMP_MAX;
                end else if (tacc < sx(corr_pkg::TEMP_MIN)) begin
                    next_temp_out = corr_pkg::TEMP_MIN;
                end else begin
                    next_temp_out = tacc[15:0];
                end
                next_valid = 1'b1;
                next_busy  = 1'b0;
                next_state = corr_pkg::S_IDLE;
            end
            default: begin
                next_state = corr_pkg::S_IDLE;
                next_busy  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            state      <= corr_pkg::S_IDLE;
            region     <= 1'b0;
            cubic_mode <= 1'b0;
            raw_c      <= '0;
            raw_t      <= '0;
            dt         <= '0;
            tmp        <= '0;
            num        <= '0;
            den        <= '0;
            reg_one    <= '0;
            reg_two    <= '0;
            y          <= '0;
            sq         <= '0;
            acc        <= '0;
            tacc       <= '0;
            busy       <= 1'b0;
            valid      <= 1'b0;
            cap_out    <= corr_pkg::RESULT_RST;
            temp_out   <= corr_pkg::RESULT_RST;
        end else begin
            state      <= next_state;
            region     <= next_region;
            cubic_mode <= next_cubic_mode;
            raw_c      <= next_raw_c;
            raw_t      <= next_raw_t;
            dt         <= next_dt;
            tmp        <= next_tmp;
            num        <= next_num;
            den        <= next_den;
            reg_one    <= next_reg_one;
            reg_two    <= next_reg_two;
            y          <= next_y;
            sq         <= next_sq;
            acc        <= next_acc;
            tacc       <= next_tacc;
            busy       <= next_busy;
            valid      <= next_valid;
            cap_out    <= next_cap_out;
            temp_out   <= next_temp_out;
        end
    end

    assign BUSY_O         = busy;
    assign RESULT_VALID_O = valid;
    assign CAP_OUT_O      = cap_out;
    assign TEMP_OUT_O     = temp_out;
endmodule : sensor_correction_math

// >>> verif/correction_props.sv
`timescale 1ns/1ps
module correction_props (
    // Clock and reset
    input wire logic        CLK_I,
    input wire logic        RESET_I,
    // Request
    input wire logic        START_I,
    input wire logic        THIRD_ORDER_I,
    // Results
    input wire logic        BUSY_O,
    input wire logic        RESULT_VALID_O,
    input wire logic [15:0] CAP_OUT_O,
    input wire logic [15:0] TEMP_OUT_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RESET_I);

    a_two_region_latency: assert property (
        START_I && !BUSY_O && !THIRD_ORDER_I |-> ##58 RESULT_VALID_O)
        else $error("late two-region");
    a_cubic_latency: assert property (
        START_I && !BUSY_O && THIRD_ORDER_I |-> ##57 RESULT_VALID_O) else $error("late cubic");
    a_busy_after_start: assert property (
        START_I && !BUSY_O |=> BUSY_O [*8]) else $error("busy not raised");
    a_valid_single_pulse: assert property (
        RESULT_VALID_O |=> !RESULT_VALID_O) else $error("valid too long");
    a_valid_ends_busy: assert property (
        RESULT_VALID_O |-> !BUSY_O && $past(BUSY_O)) else $error("valid without run");
    a_busy_drop_valid: assert property (
        $fell(BUSY_O) |-> RESULT_VALID_O) else $error("run ended without result");
    a_results_hold: assert property (
        !RESULT_VALID_O |-> $stable(CAP_OUT_O) && $stable(TEMP_OUT_O)) else $error("result moved");
    a_idle_stays_idle: assert property (
        !BUSY_O && !RESULT_VALID_O && !START_I |=> !BUSY_O) else $error("busy without start");

    c_back_to_back: cover property (RESULT_VALID_O && START_I);
    c_refused_start: cover property (BUSY_O && START_I);
    c_cap_saturated: cover property (RESULT_VALID_O && CAP_OUT_O == 16'hFFFF);
endmodule : correction_props

bind sensor_correction_math correction_props u_props (.CLK_I, .RESET_I, .START_I,
    .THIRD_ORDER_I, .BUSY_O, .RESULT_VALID_O, .CAP_OUT_O, .TEMP_OUT_O);

// >>> verif/front_end_model.sv
`timescale 1ns/1ps
module front_end_model (
    // Clock and design status
    input  wire logic        clk_i,
    input  wire logic        busy_i,
    input  wire logic        valid_i,
    // Bench requests
    input  wire logic        req_i,
    input  wire logic        poke_i,
    input  wire logic        md_i,
    input  wire logic [13:0] rc_i,
    input  wire logic [13:0] rt_i,
    // Design results
    input  wire logic [15:0] cap_i,
    input  wire logic [15:0] temp_i,
    // Conversion side
    output logic             start_o,
    output logic             mode_o,
    output logic [13:0]      raw_cap_o,
    output logic [13:0]      raw_temp_o,
    // Captured results
    output logic [15:0]      cap_o,
    output logic [15:0]      temp_o,
    output logic [7:0]       seen_o
);
    logic [1:0] pend = 2'h0;
    logic       pk   = 1'b0;

    initial start_o = 1'b0;
    initial seen_o = 8'h00;
    // Released lines show inverted data so a late sample is caught
    assign raw_cap_o  = start_o ? rc_i : ~rc_i;
    assign raw_temp_o = start_o ? rt_i : ~rt_i;
    assign mode_o     = start_o ? md_i : ~md_i;

    always @(posedge clk_i) begin
        pend <= pend + 2'(req_i) - 2'(start_o && !busy_i);
        pk   <= poke_i;
        if (valid_i) begin
            cap_o  <= cap_i;
            temp_o <= temp_i;
            seen_o <= seen_o + 8'h01;
        end
    end

    // Poke raises a request mid-run, which the design must ignore
    always @(negedge clk_i) start_o <= (pend != 2'h0 && !busy_i) || pk;
endmodule : front_end_model

// >>> verif/sensor_correction_math_tb.sv
`timescale 1ns/1ps
module sensor_correction_math_tb;
    logic        clk = 0, rst = 1, req = 0, poke = 0, md = 0;
    logic        start, busy, valid, mode;
    logic [13:0] rc = 0, rt = 0, rawc, rawt;
    logic [15:0] k [14];
    logic [15:0] cap, temp, pcap, ptemp;
    logic [7:0]  seen;
    int          n_mismatch = 0, num_checks = 0, cyc = 0;

    always #50 clk = ~clk;

    sensor_correction_math DUT (.CLK_I(clk), .RESET_I(rst), .START_I(start),
        .RAW_CAP_I(rawc), .RAW_TEMP_I(rawt), .THIRD_ORDER_I(mode), .SENSOR_OFFSET_I(k[0]),
        .REF_TEMP_I(k[1][13:0]), .OFFSET_DRIFT_I(k[2]), .OFFSET_DRIFT_SQUARE_COEF_I(k[3]),
        .GAIN_DRIFT_I(k[4]), .GAIN_DRIFT_SQUARE_COEF_I(k[5]), .REGION_BREAK_I(k[6]),
        .REGION_ONE_GAIN_I(k[7]), .REGION_ONE_SQUARE_COEF_I(k[8]), .REGION_TWO_GAIN_I(k[9]),
        .REGION_TWO_SQUARE_COEF_I(k[10]), .TEMPERATURE_GAIN_I(k[11]),
        .TEMPERATURE_OFFSET_I(k[12]), .TEMPERATURE_SQUARE_COEF_I(k[13]),
        .BUSY_O(busy), .RESULT_VALID_O(valid), .CAP_OUT_O(cap), .TEMP_OUT_O(temp));

    front_end_model FE (.clk_i(clk), .busy_i(busy), .valid_i(valid), .req_i(req),
        .poke_i(poke), .md_i(md), .rc_i(rc), .rt_i(rt), .cap_i(cap), .temp_i(temp),
        .start_o(start), .mode_o(mode), .raw_cap_o(rawc), .raw_temp_o(rawt),
        .cap_o(pcap), .temp_o(ptemp), .seen_o(seen));

    function automatic longint sg(input logic [15:0] v);
        return longint'($signed(v));
    endfunction : sg

    function automatic longint sat(input longint v, input longint lo, input longint hi);
        return v < lo ? lo : (v > hi ? hi : v);
    endfunction : sat

    function automatic longint term(input longint r, input longint g, input longint s,
                                    input longint c, input bit cu);
        longint y, q;
        y = (g * r) >>> 13;
        q = (y * y) >>> 16;
        return y + ((q * s) >>> 15) + (cu ? ((((q * y) >>> 16) * c) >>> 15) : 0);
    endfunction : term

    function automatic longint exp_cap(input bit cu);
        longint dt, nm, dn, c, b;
        dt = longint'(rt) - longint'(k[1][13:0]);
        nm = longint'(rc) - 8192 + sg(k[0])
           + ((dt * (sg(k[2]) + ((dt * sg(k[3])) >>> 14))) >>> 16);
        dn = 65536 + ((dt * (sg(k[4]) + ((dt * sg(k[5])) >>> 14))) >>> 16);
        c  = ((nm <<< 16) / (dn < 1 ? 1 : dn)) + 8192;
        b  = longint'(k[6]);
        if (cu) return sat(term(c, sg(k[7]), sg(k[8]), sg(k[10]), 1), 0, 65535);
        return sat(term(c < b ? c : b, sg(k[7]), sg(k[8]), 0, 0)
                   + term(c > b ? c - b : 0, sg(k[9]), sg(k[10]), 0, 0), 0, 65535);
    endfunction : exp_cap

    function automatic longint exp_temp();
        longint t;
        t = longint'(rt);
        return sat((((t * t) >>> 14) * sg(k[13]) >>> 15) + sg(k[12])
                   + ((sg(k[11]) * t) >>> 14), -32768, 32767);
    endfunction : exp_temp

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic run(input bit cu, input logic [13:0] c, input logic [13:0] t, input int n,
                       input bit pk);
        logic [7:0] s0;
        s0 = seen;
        md = cu;
        rc = c;
        rt = t;
        req = 1;
        repeat (n) @(negedge clk);
        req = 0;
        if (pk) begin
            repeat (10) @(negedge clk);
            chk(16'(busy), 16'h0001);
            poke = 1;
            @(negedge clk);
            poke = 0;
        end
        for (int i = 0; i < 70 * n && seen !== s0 + 8'(n); i++) @(negedge clk);
        chk(16'(seen), 16'(s0 + 8'(n)));
        chk(16'(busy), 16'h0000);
        chk(pcap, 16'(exp_cap(cu)));
        chk(ptemp, 16'(exp_temp()));
    endtask : run

    task automatic tally_and_finish();
        if (n_mismatch == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish

    // Whole run needs under 700 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    initial begin
        k = '{default: 16'h0000};
        repeat (3) @(negedge clk);
        rst = 0;
        chk(cap, 16'h0000);
        chk(temp, 16'h0000);
        k = '{16'h0064, 16'h1F40, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h2EE0,
              16'h2000, 16'h1000, 16'h3000, 16'hF000, 16'h4000, 16'h0064, 16'h0800};
        run(0, 14'h1388, 14'h1F40, 1, 0);
        run(0, 14'h3A98, 14'h1F40, 1, 1);
        run(1, 14'h3A98, 14'h1F40, 2, 0);
        k[2] = 16'h03E8;
        k[3] = 16'h0200;
        k[4] = 16'h0800;
        k[5] = 16'h0100;
        run(0, 14'h1388, 14'h1770, 1, 0);
        run(1, 14'h1388, 14'h2710, 1, 0);
        k = '{16'h7FFF, 16'h1F40, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h2EE0,
              16'h7FFF, 16'h0000, 16'h7FFF, 16'h0000, 16'h7FFF, 16'h7FFF, 16'h7FFF};
        run(0, 14'h3FFF, 14'h3FFF, 1, 0);
        k[0] = 16'h8000;
        k[11] = 16'h8000;
        k[12] = 16'h8000;
        k[13] = 16'h0000;
        run(0, 14'h0000, 14'h3FFF, 1, 0);
        tally_and_finish();
    end
endmodule : sensor_correction_math_tb
